//--- tcp_pkg.sv
// constants shared by the timer/counter/pwm block
package tcp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_INST = 4;
    localparam int CNT_W = 16;
    localparam int DB_W = 8;
    localparam int PRESC_W = 16;

    // per-instance register window
    localparam logic [7:0] INST_STRIDE = 8'h20;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_PERIOD = 5'h04;
    localparam logic [4:0] OFF_COMPARE = 5'h08;
    localparam logic [4:0] OFF_COUNT = 5'h0c;
    localparam logic [4:0] OFF_CAPTURE = 5'h10;
    localparam logic [4:0] OFF_DEADBAND = 5'h14;
    // global registers
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
    localparam logic [7:0] OFF_PRESCALE = 8'h88;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_CLK_LSB = 3;
    localparam int CTRL_REL_LSB = 5;
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_COMPL_BIT = 9;
    localparam int CTRL_W = 10;

    // counting modes
    localparam logic [1:0] MODE_FREE = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_GATED = 2'h2;
    // clock sources
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_PRESC = 2'h1;
    localparam logic [1:0] CLK_EXT = 2'h2;
    // compare relations
    localparam logic [2:0] REL_LT = 3'h0;
    localparam logic [2:0] REL_LTE = 3'h1;
    localparam logic [2:0] REL_EQ = 3'h2;
    localparam logic [2:0] REL_GTE = 3'h3;
    localparam logic [2:0] REL_GT = 3'h4;

    // irq status layout: terminal count bits, then capture bits
    localparam int IRQ_TC_LSB = 0;
    localparam int IRQ_CAP_LSB = 4;
    localparam int IRQ_W = 8;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
    localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0000;
    localparam logic [DB_W-1:0] DEADBAND_RST = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_RST = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- tcp_timer.sv
// four-instance 16-bit down-counting timer/counter/pwm with axi4-lite registers
`timescale 1ns/1ps
module tcp_timer #(
    parameter int NUM_INST = tcp_pkg::NUM_INST
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [tcp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tcp_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [tcp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tcp_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // fabric inputs, one per instance
    input wire logic [NUM_INST-1:0] ext_clk_in,
    input wire logic [NUM_INST-1:0] tmr_reset_in,
    input wire logic [NUM_INST-1:0] capture_in,
    input wire logic [NUM_INST-1:0] enable_in,
    input wire logic [NUM_INST-1:0] kill_in,
    // fabric outputs, one per instance
    output logic [NUM_INST-1:0] cmp_out,
    output logic [NUM_INST-1:0] cmp_n_out,
    output logic [NUM_INST-1:0] tc_out,
    // interrupt
    output logic irq
);
    import tcp_pkg::*;

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] new_v,
                                                 input logic [3:0] strb);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic compare(input logic [2:0] rel, input logic [CNT_W-1:0] a,
                                     input logic [CNT_W-1:0] b);
        case (rel)
            REL_LT: return a < b;
            REL_LTE: return a <= b;
            REL_EQ: return a == b;
            REL_GTE: return a >= b;
            REL_GT: return a > b;
            default: return 1'b0;
        endcase
    endfunction

    // per-instance state
    logic [CTRL_W-1:0] ctrl_reg [NUM_INST];
    logic [CNT_W-1:0] period_reg [NUM_INST];
    logic [CNT_W-1:0] compare_reg [NUM_INST];
    logic [DB_W-1:0] deadband_reg [NUM_INST];
    logic [CNT_W-1:0] count_reg [NUM_INST];
    logic [CNT_W-1:0] capture_reg [NUM_INST];
    logic [NUM_INST-1:0] run_reg, tc_set, cap_set;
    logic [IRQ_W-1:0] irq_status_reg, irq_status_next, irq_mask_reg;
    logic [PRESC_W-1:0] presc_reg, presc_cnt_reg;
    logic presc_tick, aw_hold_reg, w_hold_reg, wr_fire, wr_ok, rd_ok;
    logic [ADDR_W-1:0] waddr_reg;
    logic [DATA_W-1:0] wdata_reg, rd_val;
    logic [3:0] wstrb_reg;

    assign s_axi_awready = ~aw_hold_reg;
    assign s_axi_wready = ~w_hold_reg;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            waddr_reg <= '0;
        end else if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_comb begin
        if (waddr_reg[7]) begin
            wr_ok = waddr_reg == OFF_IRQ_STATUS || waddr_reg == OFF_IRQ_MASK || waddr_reg == OFF_PRESCALE;
        end else begin
            wr_ok = 32'(waddr_reg[6:5]) < NUM_INST && (waddr_reg[4:0] == OFF_CTRL
                || waddr_reg[4:0] == OFF_PERIOD || waddr_reg[4:0] == OFF_COMPARE
                || waddr_reg[4:0] == OFF_DEADBAND);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read mux; count is read live without touching the counter
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        if (s_axi_araddr[7]) begin
            case (s_axi_araddr)
                OFF_IRQ_STATUS: rd_val = DATA_W'(irq_status_reg);
                OFF_IRQ_MASK: rd_val = DATA_W'(irq_mask_reg);
                OFF_PRESCALE: rd_val = DATA_W'(presc_reg);
                default: rd_ok = 1'b0;
            endcase
        end else if (32'(s_axi_araddr[6:5]) < NUM_INST) begin
            case (s_axi_araddr[4:0])
                OFF_CTRL: rd_val = DATA_W'(ctrl_reg[s_axi_araddr[6:5]]);
                OFF_PERIOD: rd_val = DATA_W'(period_reg[s_axi_araddr[6:5]]);
                OFF_COMPARE: rd_val = DATA_W'(compare_reg[s_axi_araddr[6:5]]);
                OFF_COUNT: rd_val = DATA_W'(count_reg[s_axi_araddr[6:5]]);
                OFF_CAPTURE: rd_val = DATA_W'(capture_reg[s_axi_araddr[6:5]]);
                OFF_DEADBAND: rd_val = DATA_W'(deadband_reg[s_axi_araddr[6:5]]);
                default: rd_ok = 1'b0;
            endcase
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // global registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= '0;
            presc_reg <= PRESC_RST;
        end else if (wr_fire && waddr_reg == OFF_IRQ_MASK) begin
            irq_mask_reg <= IRQ_W'(merge(DATA_W'(irq_mask_reg), wdata_reg, wstrb_reg));
        end else if (wr_fire && waddr_reg == OFF_PRESCALE) begin
            presc_reg <= PRESC_W'(merge(DATA_W'(presc_reg), wdata_reg, wstrb_reg));
        end
    end

    // write one to clear; a new event in the same cycle wins
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_fire && waddr_reg == OFF_IRQ_STATUS && wstrb_reg[0]) begin
            irq_status_next = irq_status_reg & ~wdata_reg[IRQ_W-1:0];
        end
        irq_status_next[IRQ_TC_LSB +: NUM_INST] = irq_status_next[IRQ_TC_LSB +: NUM_INST] | tc_set;
        irq_status_next[IRQ_CAP_LSB +: NUM_INST] = irq_status_next[IRQ_CAP_LSB +: NUM_INST] | cap_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= '0;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq <= |(irq_status_next & irq_mask_reg);
        end
    end

    // shared prescaled tick: one pulse every presc_reg+1 bus clocks
    assign presc_tick = presc_cnt_reg == '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_cnt_reg <= '0;
        end else if (presc_tick) begin
            presc_cnt_reg <= presc_reg;
        end else begin
            presc_cnt_reg <= presc_cnt_reg - 1'b1;
        end
    end

    for (genvar k = 0; k < NUM_INST; k++) begin : g_inst
        logic hit, start, ext_lvl_reg, ext_rise, tick, step;
        logic rst_prev_reg, cap_prev_reg, rst_rise, raw, raw_reg;
        logic [2:0] sync_reg;
        logic [DB_W-1:0] db_cnt_reg;
        logic [1:0] mode;

        assign hit = wr_fire && !waddr_reg[7] && waddr_reg[6:5] == 2'(k);
        assign start = hit && waddr_reg[4:0] == OFF_CTRL && wstrb_reg[1] && wdata_reg[CTRL_START_BIT];
        assign mode = ctrl_reg[k][CTRL_MODE_LSB +: 2];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctrl_reg[k] <= CTRL_RST;
                period_reg[k] <= PERIOD_RST;
                compare_reg[k] <= COMPARE_RST;
                deadband_reg[k] <= DEADBAND_RST;
            end else if (hit) begin
                case (waddr_reg[4:0])
                    OFF_CTRL: ctrl_reg[k] <= CTRL_W'(merge(DATA_W'(ctrl_reg[k]), wdata_reg, wstrb_reg))
                        & ~(CTRL_W'(1) << CTRL_START_BIT);
                    OFF_PERIOD: period_reg[k] <= CNT_W'(merge(DATA_W'(period_reg[k]), wdata_reg, wstrb_reg));
                    OFF_COMPARE: compare_reg[k] <= CNT_W'(merge(DATA_W'(compare_reg[k]), wdata_reg, wstrb_reg));
                    OFF_DEADBAND: deadband_reg[k] <= DB_W'(merge(DATA_W'(deadband_reg[k]), wdata_reg, wstrb_reg));
                    default: ctrl_reg[k] <= ctrl_reg[k];
                endcase
            end
        end

        // external clock pin: three flops, edge counted when last two agree
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync_reg <= '0;
                ext_lvl_reg <= 1'b0;
            end else begin
                sync_reg <= {sync_reg[1:0], ext_clk_in[k]};
                if (sync_reg[1] == sync_reg[2]) begin
                    ext_lvl_reg <= sync_reg[2];
                end
            end
        end
        assign ext_rise = sync_reg[1] & sync_reg[2] & ~ext_lvl_reg;

        always_comb begin
            case (ctrl_reg[k][CTRL_CLK_LSB +: 2])
                CLK_BUS: tick = 1'b1;
                CLK_PRESC: tick = presc_tick;
                CLK_EXT: tick = ext_rise;
                default: tick = 1'b0;
            endcase
        end
        assign step = run_reg[k] && tick && (mode != MODE_GATED || enable_in[k]);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rst_prev_reg <= 1'b0;
                cap_prev_reg <= 1'b0;
            end else begin
                rst_prev_reg <= tmr_reset_in[k];
                cap_prev_reg <= capture_in[k];
            end
        end
        assign rst_rise = tmr_reset_in[k] & ~rst_prev_reg;
        assign cap_set[k] = capture_in[k] & ~cap_prev_reg;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                capture_reg[k] <= '0;
            end else if (cap_set[k]) begin
                capture_reg[k] <= count_reg[k];
            end
        end

        assign tc_set[k] = step && count_reg[k] == '0;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                count_reg[k] <= '0;
                run_reg[k] <= 1'b0;
                tc_out[k] <= 1'b0;
            end else begin
                if (tick || !run_reg[k]) begin
                    tc_out[k] <= 1'b0;
                end
                if (start || rst_rise) begin
                    count_reg[k] <= period_reg[k];
                    run_reg[k] <= run_reg[k] | start;
                end else if (!ctrl_reg[k][CTRL_EN_BIT]) begin
                    run_reg[k] <= 1'b0;
                end else if (tc_set[k]) begin
                    count_reg[k] <= period_reg[k];
                    tc_out[k] <= 1'b1;
                    if (mode == MODE_ONESHOT) begin
                        run_reg[k] <= 1'b0;
                    end
                end else if (step) begin
                    count_reg[k] <= count_reg[k] - 1'b1;
                end
            end
        end

        assign raw = compare(ctrl_reg[k][CTRL_REL_LSB +: 3], count_reg[k], compare_reg[k]);

        // deadband: both outputs low for deadband_reg+1 clocks after each change
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                raw_reg <= 1'b0;
                db_cnt_reg <= '0;
                cmp_out[k] <= 1'b0;
                cmp_n_out[k] <= 1'b0;
            end else begin
                raw_reg <= raw;
                if (raw != raw_reg) begin
                    db_cnt_reg <= deadband_reg[k];
                end else if (db_cnt_reg != '0) begin
                    db_cnt_reg <= db_cnt_reg - 1'b1;
                end
                if (kill_in[k] || raw != raw_reg || db_cnt_reg != '0) begin
                    cmp_out[k] <= 1'b0;
                    cmp_n_out[k] <= 1'b0;
                end else begin
                    cmp_out[k] <= raw_reg;
                    cmp_n_out[k] <= ~raw_reg & ctrl_reg[k][CTRL_COMPL_BIT];
                end
            end
        end
    end
endmodule

//--- tcp_fabric.sv
// routing fabric model driving the timer's fabric inputs
`timescale 1ns/1ps
module tcp_fabric #(
    parameter int EXT_HALF = 5
) (
    // clock
    input wire logic aclk,
    // requests from the bench
    input wire logic [3:0] ext_run,
    input wire logic [3:0] rst_req,
    input wire logic [3:0] cap_req,
    input wire logic [3:0] en_req,
    input wire logic [3:0] kill_req,
    // fabric signals into the timer
    output logic [3:0] ext_clk_in,
    output logic [3:0] tmr_reset_in,
    output logic [3:0] capture_in,
    output logic [3:0] enable_in,
    output logic [3:0] kill_in
);
    int half_cnt = 0;
    // external clock runs only while requested, idles low
    always @(posedge aclk) begin
        half_cnt <= (half_cnt == EXT_HALF - 1) ? 0 : half_cnt + 1;
        for (int k = 0; k < 4; k++) begin
            if (!ext_run[k]) begin
                ext_clk_in[k] <= 1'b0;
            end else if (half_cnt == EXT_HALF - 1) begin
                ext_clk_in[k] <= ~ext_clk_in[k];
            end
        end
    end
    always @(posedge aclk) begin
        tmr_reset_in <= rst_req;
        capture_in <= cap_req;
        enable_in <= en_req;
        kill_in <= kill_req;
    end
endmodule

//--- tcp_timer_assertions.sv
// port-level assertions for the timer block
`timescale 1ns/1ps
module tcp_timer_assertions #(
    parameter int NUM_INST = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [tcp_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // fabric
    input wire logic [NUM_INST-1:0] kill_in,
    input wire logic [NUM_INST-1:0] cmp_out,
    input wire logic [NUM_INST-1:0] cmp_n_out,
    input wire logic [NUM_INST-1:0] tc_out,
    input wire logic irq
);
    import tcp_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_kill_gate: assert property (((kill_in & $past(kill_in)) & (cmp_out | cmp_n_out)) == '0)
        else $error("output active under kill");
    chk_pair_apart: assert property ((cmp_out & cmp_n_out) == '0)
        else $error("both pwm outputs high");
    chk_deadband_gap: assert property (((cmp_out & $past(cmp_n_out)) | (cmp_n_out & $past(cmp_out))) == '0)
        else $error("pwm swap without gap");
    cov_irq: cover property ($rose(irq));
    cov_tc: cover property ($rose(|tc_out));
    cov_kill: cover property (|(kill_in & $past(cmp_out)));
endmodule
bind tcp_timer tcp_timer_assertions #(.NUM_INST(NUM_INST)) u_chk (.*);

//--- tcp_timer_test.sv
// self-checking bench for the timer/counter/pwm block
`timescale 1ns/1ps
module automatic tcp_timer_test;
    import tcp_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] ext_run = '0, rst_req = '0, cap_req = '0, en_req = '0, kill_req = '0;
    logic [3:0] ext_clk, tmr_rst, cap, en, kill, cmp, cmp_n, tc;
    int miscompares = 0, check_count = 0, cycles = 0;
    int gap_run = 0, last_gap = 0;
    always #4 aclk = ~aclk;
    tcp_timer uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clk_in(ext_clk),
        .tmr_reset_in(tmr_rst), .capture_in(cap), .enable_in(en), .kill_in(kill), .cmp_out(cmp),
        .cmp_n_out(cmp_n), .tc_out(tc), .irq(irq)
    );
    tcp_fabric fab (
        .aclk(aclk), .ext_run(ext_run), .rst_req(rst_req), .cap_req(cap_req), .en_req(en_req),
        .kill_req(kill_req), .ext_clk_in(ext_clk), .tmr_reset_in(tmr_rst), .capture_in(cap),
        .enable_in(en), .kill_in(kill)
    );
    // length of the latest both-low stretch on pair 3
    always @(negedge aclk) begin
        if (cmp[3] === 1'b0 && cmp_n[3] === 1'b0) begin
            gap_run++;
        end else if (gap_run != 0) begin
            last_gap = gap_run;
            gap_run = 0;
        end
    end
    // ceiling well above the expected run length
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            $display("ERROR %0t timeout", $time);
            final_report();
        end
    end
    task final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function logic [7:0] ra(input int k, input logic [4:0] off);
        return INST_STRIDE * 8'(k) + 8'(off);
    endfunction
    function logic [31:0] ctl(input logic [1:0] m, input logic [1:0] c, input logic [2:0] rel, input logic cm);
        return {22'h0, cm, 1'b1, rel, c, m, 1'b1};
    endfunction
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, ad = 0, wd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ah = awvalid && awready && !ad;
            wh = wvalid && wready && !wd;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            ad = ad | ah;
            wd = wd | wh;
        end while (!(ad && wd));
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check_eq({30'h0, r}, 32'(RESP_OKAY), "bresp");
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check_eq({30'h0, r}, 32'(RESP_OKAY), "rresp");
        check_eq(d, exp, what);
    endtask
    task measure_tc(input int k, input int per, input int wid);
        int n = 0;
        do @(negedge aclk); while (tc[k] !== 1'b0);
        do @(negedge aclk); while (tc[k] !== 1'b1);
        do begin
            @(negedge aclk);
            n++;
        end while (tc[k] === 1'b1);
        check_eq(32'(n), 32'(wid), "tc width");
        do begin
            @(negedge aclk);
            n++;
        end while (tc[k] !== 1'b1);
        check_eq(32'(n), 32'(per), "tc period");
    endtask
    task s_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(ra(0, OFF_CTRL), 32'(CTRL_RST), "ctrl rst");
        rd_chk(ra(3, OFF_DEADBAND), 32'(DEADBAND_RST), "db rst");
        wr(ra(1, OFF_PERIOD), 32'h0000_1234);
        rd_chk(ra(1, OFF_PERIOD), 32'h0000_1234, "period 1");
        rd_chk(ra(0, OFF_PERIOD), 32'(PERIOD_RST), "period 0");
        rd(8'hfc, d, r);
        check_eq({30'h0, r}, 32'(RESP_SLVERR), "unmapped");
        axi_wr(ra(0, OFF_COUNT), 32'h0000_0005, r);
        check_eq({30'h0, r}, 32'(RESP_SLVERR), "count ro");
    endtask
    task s_clocks();
        wr(ra(0, OFF_PERIOD), 32'h0000_0003);
        wr(ra(0, OFF_CTRL), ctl(MODE_FREE, CLK_BUS, REL_LT, 1'b0));
        measure_tc(0, 4, 1);
        wr(OFF_PRESCALE, 32'h0000_0001);
        wr(ra(0, OFF_CTRL), ctl(MODE_FREE, CLK_PRESC, REL_LT, 1'b0));
        measure_tc(0, 8, 2);
        wr(ra(0, OFF_CTRL), ctl(MODE_FREE, CLK_EXT, REL_LT, 1'b0));
        ext_run[0] <= 1'b1;
        measure_tc(0, 40, 10);
        wr(ra(0, OFF_CTRL), 32'h0000_0000);
        ext_run <= '0;
    endtask
    task s_oneshot();
        int n = 0;
        wr(ra(1, OFF_PERIOD), 32'h0000_0005);
        wr(ra(1, OFF_CTRL), ctl(MODE_ONESHOT, CLK_BUS, REL_LT, 1'b0));
        do @(negedge aclk); while (tc[1] !== 1'b1);
        repeat (30) begin
            @(negedge aclk);
            if (tc[1] !== 1'b0) n++;
        end
        check_eq(32'(n), 32'h0000_0000, "oneshot tc");
        rd_chk(ra(1, OFF_COUNT), 32'h0000_0005, "oneshot count");
    endtask
    task s_gated();
        logic [31:0] c;
        logic [1:0] r;
        wr(ra(2, OFF_PERIOD), 32'h0000_0100);
        wr(ra(2, OFF_CTRL), ctl(MODE_GATED, CLK_BUS, REL_LT, 1'b0));
        rd_chk(ra(2, OFF_COUNT), 32'h0000_0100, "start load");
        rd_chk(ra(2, OFF_COUNT), 32'h0000_0100, "gated hold");
        en_req[2] <= 1'b1;
        repeat (20) @(posedge aclk);
        en_req[2] <= 1'b0;
        rd(ra(2, OFF_COUNT), c, r);
        check_eq({31'h0, c < 32'h0000_0100 && c > 32'h0000_00e0}, 32'h0000_0001, "gated run");
        cap_req[2] <= 1'b1;
        @(posedge aclk);
        cap_req[2] <= 1'b0;
        rd_chk(ra(2, OFF_CAPTURE), c, "capture");
        rst_req[2] <= 1'b1;
        @(posedge aclk);
        rst_req[2] <= 1'b0;
        rd_chk(ra(2, OFF_COUNT), 32'h0000_0100, "reset load");
        rd_chk(ra(2, OFF_CAPTURE), c, "capture kept");
    endtask
    task s_irq();
        rd_chk(OFF_IRQ_STATUS, 32'h0000_0043, "status");
        wr(OFF_IRQ_MASK, 32'h0000_0040);
        repeat (2) @(negedge aclk);
        check_eq({31'h0, irq}, 32'h0000_0001, "irq cap");
        wr(OFF_IRQ_STATUS, 32'h0000_0040);
        repeat (2) @(negedge aclk);
        check_eq({31'h0, irq}, 32'h0000_0000, "irq clr");
        wr(OFF_IRQ_MASK, 32'h0000_0003);
        repeat (2) @(negedge aclk);
        check_eq({31'h0, irq}, 32'h0000_0001, "irq tc");
        wr(OFF_IRQ_STATUS, 32'h0000_0003);
        rd_chk(OFF_IRQ_STATUS, 32'h0000_0000, "status clr");
    endtask
    task s_compare();
        logic [4:0] tbl [3] = '{5'b01110, 5'b00011, 5'b11000};
        logic [15:0] cv [3] = '{16'h000a, 16'h000b, 16'h0009};
        wr(ra(3, OFF_PERIOD), 32'h0000_000a);
        for (int i = 0; i < 3; i++) begin
            wr(ra(3, OFF_COMPARE), {16'h0, cv[i]});
            for (int r = 0; r < 5; r++) begin
                wr(ra(3, OFF_CTRL), ctl(MODE_GATED, CLK_BUS, 3'(r), 1'b1));
                repeat (8) @(negedge aclk);
                check_eq({30'h0, cmp[3], cmp_n[3]}, {30'h0, tbl[i][r], ~tbl[i][r]}, "rel");
            end
        end
        wr(ra(3, OFF_CTRL), ctl(MODE_GATED, CLK_BUS, REL_EQ, 1'b0));
        repeat (8) @(negedge aclk);
        check_eq({30'h0, cmp[3], cmp_n[3]}, 32'h0000_0000, "no compl");
        wr(ra(3, OFF_COMPARE), 32'h0000_000a);
        wr(ra(3, OFF_CTRL), ctl(MODE_GATED, CLK_BUS, REL_EQ, 1'b1));
        kill_req[3] <= 1'b1;
        repeat (4) @(negedge aclk);
        check_eq({30'h0, cmp[3], cmp_n[3]}, 32'h0000_0000, "kill");
        @(posedge aclk);
        kill_req[3] <= 1'b0;
        repeat (8) @(negedge aclk);
        check_eq({30'h0, cmp[3], cmp_n[3]}, 32'h0000_0002, "unkill");
        wr(ra(3, OFF_DEADBAND), 32'h0000_0005);
        wr(ra(3, OFF_COMPARE), 32'h0000_0009);
        do @(negedge aclk); while (cmp_n[3] !== 1'b1);
        @(posedge aclk);
        check_eq(32'(last_gap), 32'h0000_0006, "deadband");
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs();
        s_clocks();
        s_oneshot();
        s_gated();
        s_irq();
        s_compare();
        final_report();
    end
endmodule
